// >>> rtl/fault_cfg_pkg.sv
// Register map, field layout, carrier types and timing constants of the fault and isolation block
package fault_cfg_pkg;

  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] STATE_OFFSET = 8'h08;

  // Configuration word field positions
  localparam int TOPOLOGY_SELECT_BIT = 0;
  localparam int SENSE_SWITCH_EN_BIT = 1;
  localparam int FAULT_PIN_FUNCTION_LSB = 2;
  localparam int EXT_TRIGGER_PIN_MASK_BIT = 4;
  localparam int EXT_TRIG_BRIDGE_ACTION_BIT = 5;
  localparam int EXT_TRIG_REVERSE_ACTION_BIT = 6;
  localparam int EXT_TRIG_PHASE_ACTION_BIT = 7;
  localparam int CURRENT_DEPENDENT_ISOLATION_BIT = 8;
  localparam int NEG_OVERCURRENT_THRESHOLD_LSB = 16;
  localparam logic [31:0] CFG_WRITABLE_MASK = 32'h007f_01ff;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Status word bit positions, all write-one-to-clear
  localparam int POWER_ON_RESET_FLAG_BIT = 0;
  localparam int SERIAL_ERROR_FLAG_BIT = 1;
  localparam int TEMP_WARNING_FLAG_BIT = 2;
  localparam int EXT_TRIGGER_FAULT_BIT = 3;
  localparam int PUMP_UNDERVOLTAGE_FLAG_BIT = 4;
  localparam int NEG_OVERCURRENT_FLAG_BIT = 5;
  localparam int POS_OVERCURRENT_FLAG_BIT = 6;
  localparam int WATCHDOG_TIMEOUT_FLAG_BIT = 7;
  localparam int BRIDGE_POS_UV_FLAG_BIT = 8;
  localparam int BRIDGE_NEG_UV_FLAG_BIT = 9;
  localparam int REVERSE_GATE_UV_FLAG_BIT = 10;
  localparam int STATUS_WIDTH = 11;
  localparam logic [STATUS_WIDTH-1:0] STATUS_RESET = 11'h001;
  // Flags that pull the fault pin; the external trigger is gated separately by its mask
  localparam logic [STATUS_WIDTH-1:0] PIN_FAULT_MASK = 11'h7f2;

  // Fault pin functions
  localparam logic [1:0] PIN_FUNC_FAULT_FLAG = 2'h0;
  localparam logic [1:0] PIN_FUNC_CLOCK_OUT = 2'h1;

  // Timing
  localparam int CLK_FREQ_MHZ = 125;
  localparam int TRIGGER_BLANK_US = 10;
  localparam int TRIGGER_BLANK_CYCLES = TRIGGER_BLANK_US * CLK_FREQ_MHZ;
  localparam int BLANK_COUNT_WIDTH = 11;
  localparam int CLOCK_OUT_HALF_CYCLES = 4;

  // Threshold is field value plus one, in 1 mV steps
  localparam int THRESHOLD_WIDTH = 7;
  localparam int MONITOR_MV_WIDTH = 8;

  typedef struct packed {
    logic serial_error;
    logic pump_undervoltage;
    logic neg_overcurrent;
    logic pos_overcurrent;
    logic watchdog_timeout;
    logic bridge_pos_uv;
    logic bridge_neg_uv;
    logic reverse_gate_uv;
    logic temp_warning;
  } fault_event_type;

  typedef struct packed {
    logic bridge_off;
    logic reverse_off;
    logic [2:0] phase_hold_off;
  } isolation_action_type;

endpackage

// >>> rtl/fault_isolation_ctrl.sv
// Fault pin, topology selection, sense switch and isolation fault actions behind an APB slave
// What this block does
// - Topology select bit 1 picks common drain, 0 picks common source.
// - Topology select resets to common source.
// - Reverse gate output inverts in common drain, else normal polarity.
// - In common drain the reverse status shows the reverse MOSFET state.
// - In common drain the reverse gate undervoltage fault is never flagged.
// - Sense switch closed while its enable bit is 1, open at 0.
// - Sense switch stays open during sleep regardless of enable.
// - Faults go to pin and status, except warning, reset flag, overvoltage.
// - Two-bit function field: flag, clock output, or input-only pin.
// - Fault flag pin low while any fault present or latched; default function.
// - Clock function outputs square wave derived from the internal clock.
// - External low on an undriven pin latches the external trigger fault.
// - Unmasked trigger holds pin low until its flag is cleared.
// - Trigger latches bridge driver off when bridge action bit is 1.
// - Trigger latches reverse driver off at once if action 1, isolation 0.
// - With current-dependent isolation, reverse goes off once current exceeds threshold.
// - Reverse action bit 0 keeps reverse driver on after a trigger.
// - Phase action 1 keeps already-off phase drivers off until trigger cleared.
// - Trigger detection ignored for 10 us after the device releases the pin.
// - Every register write returns the status word on the serial output.
// - Fault bits stay latched until the host writes 1 to them.
// - Logic overvoltage pulls pin low, unmaskable, with no status bit.
// - After reset, configuration is at defaults, faults clear, reset flag set.
// - Negative overcurrent threshold is a 7-bit field plus one millivolt.
//
// The placing of the registers and the APB register port are this design's own decisions.
module fault_isolation_ctrl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fault_cfg_pkg::fault_event_type fault_events_in,
  input wire logic logic_overvoltage_in,
  input wire logic sleep_in,
  input wire logic reverse_gate_cmd_in,
  input wire logic reverse_mosfet_state_in,
  input wire logic reverse_gate_monitor_in,
  input wire logic [2:0] phase_off_in,
  input wire logic [7:0] neg_overcurrent_mv_in,
  input wire logic fault_pin_in,
  output logic fault_pin_out,
  output logic fault_pin_oe_out,
  output logic reverse_gate_out,
  output logic reverse_driver_state_out,
  output logic sense_switch_out,
  output fault_cfg_pkg::isolation_action_type isolation_out,
  output logic [31:0] status_echo_out,
  output logic status_echo_valid_out
);

  typedef enum logic [2:0] {
    REV_ON = 3'b001,
    REV_WAIT_CURRENT = 3'b010,
    REV_OFF = 3'b100
  } reverse_state_type;

  logic [31:0] cfg_r;
  logic [fault_cfg_pkg::STATUS_WIDTH-1:0] status_r;
  logic [fault_cfg_pkg::STATUS_WIDTH-1:0] status_nxt;
  logic [fault_cfg_pkg::STATUS_WIDTH-1:0] status_set;
  logic [fault_cfg_pkg::STATUS_WIDTH-1:0] status_clr;
  reverse_state_type rev_state_r;
  logic pin_sync1_r;
  logic pin_sync2_r;
  logic oe_prev_r;
  logic [fault_cfg_pkg::BLANK_COUNT_WIDTH-1:0] blank_cnt_r;
  logic [2:0] clk_div_r;
  logic clk_wave_r;
  logic trigger_detect;
  logic pin_pull_low;
  logic setup_phase;
  logic access_done;
  logic bus_write;
  logic cfg_sel;
  logic status_sel;
  logic state_sel;
  logic common_drain;
  logic [1:0] pin_function;
  logic [7:0] threshold_mv;
  logic ext_flag_cleared;

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign bus_write = access_done && pwrite;
  assign cfg_sel = paddr == fault_cfg_pkg::CFG_OFFSET;
  assign status_sel = paddr == fault_cfg_pkg::STATUS_OFFSET;
  assign state_sel = paddr == fault_cfg_pkg::STATE_OFFSET;
  assign common_drain = cfg_r[fault_cfg_pkg::TOPOLOGY_SELECT_BIT];
  assign pin_function = cfg_r[fault_cfg_pkg::FAULT_PIN_FUNCTION_LSB +: 2];
  // Field plus one millivolt; widening first so 127 does not wrap
  assign threshold_mv = {1'b0, cfg_r[fault_cfg_pkg::NEG_OVERCURRENT_THRESHOLD_LSB +:
    fault_cfg_pkg::THRESHOLD_WIDTH]} + 8'h01;
  assign ext_flag_cleared = !status_r[fault_cfg_pkg::EXT_TRIGGER_FAULT_BIT];

  // APB slave: data is prepared in the setup cycle so the answer comes from flops
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      pready <= setup_phase;
      pslverr <= setup_phase && !(cfg_sel || status_sel || state_sel);
      if (setup_phase && !pwrite)
      begin
        if (cfg_sel)
          prdata <= cfg_r;
        else if (status_sel)
          prdata <= {{(32 - fault_cfg_pkg::STATUS_WIDTH){1'b0}}, status_r};
        else if (state_sel)
          prdata <= {25'h000_0000, rev_state_r == REV_OFF, reverse_driver_state_out,
            isolation_out};
        else
          prdata <= 32'h0000_0000;
      end
    end
  end

  // Configuration register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cfg_r <= fault_cfg_pkg::CFG_RESET;
    else if (ce_in && bus_write && cfg_sel)
      cfg_r <= pwdata & fault_cfg_pkg::CFG_WRITABLE_MASK;
  end

  // Status echo on every write
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      status_echo_out <= 32'h0000_0000;
      status_echo_valid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      status_echo_valid_out <= bus_write;
      if (bus_write)
        status_echo_out <= {{(32 - fault_cfg_pkg::STATUS_WIDTH){1'b0}}, status_r};
    end
  end

  // Status flags: set wins over a write-one clear
  always_comb
  begin
    status_set = '0;
    status_set[fault_cfg_pkg::SERIAL_ERROR_FLAG_BIT] = fault_events_in.serial_error;
    status_set[fault_cfg_pkg::TEMP_WARNING_FLAG_BIT] = fault_events_in.temp_warning;
    status_set[fault_cfg_pkg::EXT_TRIGGER_FAULT_BIT] = trigger_detect;
    status_set[fault_cfg_pkg::PUMP_UNDERVOLTAGE_FLAG_BIT] = fault_events_in.pump_undervoltage;
    status_set[fault_cfg_pkg::NEG_OVERCURRENT_FLAG_BIT] = fault_events_in.neg_overcurrent;
    status_set[fault_cfg_pkg::POS_OVERCURRENT_FLAG_BIT] = fault_events_in.pos_overcurrent;
    status_set[fault_cfg_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = fault_events_in.watchdog_timeout;
    status_set[fault_cfg_pkg::BRIDGE_POS_UV_FLAG_BIT] = fault_events_in.bridge_pos_uv;
    status_set[fault_cfg_pkg::BRIDGE_NEG_UV_FLAG_BIT] = fault_events_in.bridge_neg_uv;
    status_set[fault_cfg_pkg::REVERSE_GATE_UV_FLAG_BIT] =
      fault_events_in.reverse_gate_uv && !common_drain;
    status_clr = (bus_write && status_sel) ?
      pwdata[fault_cfg_pkg::STATUS_WIDTH-1:0] : '0;
    status_nxt = (status_r & ~status_clr) | status_set;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      status_r <= fault_cfg_pkg::STATUS_RESET;
    else if (ce_in)
      status_r <= status_nxt;
  end

  // Two-stage synchroniser for the pin input
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_sync1_r <= 1'b1;
      pin_sync2_r <= 1'b1;
    end
    else if (ce_in)
    begin
      pin_sync1_r <= fault_pin_in;
      pin_sync2_r <= pin_sync1_r;
    end
  end

  // Blanking after our own release, so the slow rising edge is not seen as a trigger
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      oe_prev_r <= 1'b0;
      blank_cnt_r <= '0;
    end
    else if (ce_in)
    begin
      oe_prev_r <= fault_pin_oe_out;
      if (oe_prev_r && !fault_pin_oe_out)
        blank_cnt_r <= fault_cfg_pkg::BLANK_COUNT_WIDTH'(fault_cfg_pkg::TRIGGER_BLANK_CYCLES);
      else if (blank_cnt_r != '0)
        blank_cnt_r <= blank_cnt_r - fault_cfg_pkg::BLANK_COUNT_WIDTH'(1);
    end
  end

  // Synchroniser lag is covered because a release always reloads the blanking count
  assign trigger_detect = !pin_sync2_r && !fault_pin_oe_out && !oe_prev_r &&
    blank_cnt_r == '0;

  // Fault pin drive: only pin faults, the unmasked trigger and overvoltage pull it
  assign pin_pull_low = |(status_r & fault_cfg_pkg::PIN_FAULT_MASK) ||
    (status_r[fault_cfg_pkg::EXT_TRIGGER_FAULT_BIT] &&
     !cfg_r[fault_cfg_pkg::EXT_TRIGGER_PIN_MASK_BIT]) ||
    logic_overvoltage_in;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      clk_div_r <= 3'h0;
      clk_wave_r <= 1'b0;
    end
    else if (ce_in)
    begin
      if (clk_div_r == 3'(fault_cfg_pkg::CLOCK_OUT_HALF_CYCLES - 1))
      begin
        clk_div_r <= 3'h0;
        clk_wave_r <= !clk_wave_r;
      end
      else
        clk_div_r <= clk_div_r + 3'h1;
    end
  end

  // Open drain: the pad value is always low, the enable does the work
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      fault_pin_out <= 1'b0;
      fault_pin_oe_out <= 1'b1;
    end
    else if (ce_in)
    begin
      fault_pin_out <= 1'b0;
      if (logic_overvoltage_in)
        fault_pin_oe_out <= 1'b1;
      else
      begin
        case (pin_function)
          fault_cfg_pkg::PIN_FUNC_FAULT_FLAG: fault_pin_oe_out <= pin_pull_low;
          fault_cfg_pkg::PIN_FUNC_CLOCK_OUT: fault_pin_oe_out <= !clk_wave_r;
          default: fault_pin_oe_out <= 1'b0;
        endcase
      end
    end
  end

  // Reverse driver isolation after a trigger
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rev_state_r <= REV_ON;
    else if (ce_in)
    begin
      case (rev_state_r)
        REV_ON:
        begin
          if (trigger_detect && cfg_r[fault_cfg_pkg::EXT_TRIG_REVERSE_ACTION_BIT])
          begin
            if (cfg_r[fault_cfg_pkg::CURRENT_DEPENDENT_ISOLATION_BIT])
              rev_state_r <= REV_WAIT_CURRENT;
            else
              rev_state_r <= REV_OFF;
          end
        end
        REV_WAIT_CURRENT:
        begin
          if (ext_flag_cleared)
            rev_state_r <= REV_ON;
          else if (neg_overcurrent_mv_in > threshold_mv)
            rev_state_r <= REV_OFF;
        end
        REV_OFF:
        begin
          if (ext_flag_cleared)
            rev_state_r <= REV_ON;
        end
        default: rev_state_r <= REV_ON;
      endcase
    end
  end

  // Isolation latches in one process, so the output word has a single driver
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      isolation_out.bridge_off <= 1'b0;
      isolation_out.phase_hold_off <= 3'h0;
      isolation_out.reverse_off <= 1'b0;
    end
    else if (ce_in)
    begin
      isolation_out.reverse_off <= rev_state_r == REV_OFF;
      if (trigger_detect)
      begin
        isolation_out.bridge_off <= cfg_r[fault_cfg_pkg::EXT_TRIG_BRIDGE_ACTION_BIT];
        isolation_out.phase_hold_off <= phase_off_in &
          {3{cfg_r[fault_cfg_pkg::EXT_TRIG_PHASE_ACTION_BIT]}};
      end
      else if (ext_flag_cleared)
      begin
        isolation_out.bridge_off <= 1'b0;
        isolation_out.phase_hold_off <= 3'h0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      reverse_gate_out <= 1'b0;
      reverse_driver_state_out <= 1'b0;
      sense_switch_out <= 1'b0;
    end
    else if (ce_in)
    begin
      // Reverse gate follows the command unless isolation holds it off
      reverse_gate_out <= (reverse_gate_cmd_in && rev_state_r != REV_OFF) ^
        common_drain;
      reverse_driver_state_out <= common_drain ? reverse_mosfet_state_in :
        reverse_gate_monitor_in;
      sense_switch_out <= cfg_r[fault_cfg_pkg::SENSE_SWITCH_EN_BIT] && !sleep_in;
    end
  end

  a_topology_polarity: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && rev_state_r != REV_OFF ##1 ce_in |->
    reverse_gate_out == ($past(reverse_gate_cmd_in) ^ $past(common_drain)))
    else $error("Reverse gate polarity wrong");

  a_cd_gate_uv: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && common_drain && !status_r[fault_cfg_pkg::REVERSE_GATE_UV_FLAG_BIT] &&
    !(bus_write && cfg_sel) |=> !status_r[fault_cfg_pkg::REVERSE_GATE_UV_FLAG_BIT])
    else $error("Reverse gate undervoltage flagged in common drain");

  a_sleep_switch: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && sleep_in |=> !sense_switch_out)
    else $error("Sense switch closed in sleep");

  a_flag_pin_low: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && pin_function == fault_cfg_pkg::PIN_FUNC_FAULT_FLAG &&
    (status_r & fault_cfg_pkg::PIN_FAULT_MASK) != '0 |=> fault_pin_oe_out)
    else $error("Fault pin released while a fault is latched");

  a_trigger_latch: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && trigger_detect |=> status_r[fault_cfg_pkg::EXT_TRIGGER_FAULT_BIT])
    else $error("External trigger not latched");

  a_blank_window: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && oe_prev_r && !fault_pin_oe_out |=>
    blank_cnt_r == fault_cfg_pkg::BLANK_COUNT_WIDTH'(fault_cfg_pkg::TRIGGER_BLANK_CYCLES) &&
    !trigger_detect)
    else $error("Trigger blanking not started");

  a_reverse_immediate: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && rev_state_r == REV_ON && trigger_detect &&
    cfg_r[fault_cfg_pkg::EXT_TRIG_REVERSE_ACTION_BIT] &&
    !cfg_r[fault_cfg_pkg::CURRENT_DEPENDENT_ISOLATION_BIT] ##1 ce_in [*2] |->
    isolation_out.reverse_off)
    else $error("Reverse driver not isolated after trigger");

  a_w1c_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && status_r[fault_cfg_pkg::SERIAL_ERROR_FLAG_BIT] &&
    !(bus_write && status_sel && pwdata[fault_cfg_pkg::SERIAL_ERROR_FLAG_BIT]) |=>
    status_r[fault_cfg_pkg::SERIAL_ERROR_FLAG_BIT])
    else $error("Latched flag lost without a clear");

  a_set_wins: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && fault_events_in.watchdog_timeout && bus_write && status_sel |=>
    status_r[fault_cfg_pkg::WATCHDOG_TIMEOUT_FLAG_BIT])
    else $error("Clear beat an active fault");

  a_write_echo: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && bus_write |=> status_echo_valid_out &&
    status_echo_out[fault_cfg_pkg::STATUS_WIDTH-1:0] == $past(status_r))
    else $error("Status not echoed on write");

  a_overvoltage_pin: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && logic_overvoltage_in |=> fault_pin_oe_out)
    else $error("Overvoltage did not pull the fault pin");

endmodule

// >>> sim/fault_line_model.sv
// Shared open-drain fault line with an outside party that may pull it low
module fault_line_model (
  input wire logic oe_in,
  input wire logic pull_in,
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulled up, so the line reads high once both parties let go
  assign pin_out = !(oe_in || pull_in);
endmodule

// >>> sim/tb_fault_isolation_ctrl.sv
// Self-checking bench for the fault pin and isolation configuration block
module tb_fault_isolation_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CFG = fault_cfg_pkg::CFG_OFFSET;
  localparam logic [7:0] STS = fault_cfg_pkg::STATUS_OFFSET;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic pdat;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fault_cfg_pkg::fault_event_type ev = '0;
  logic ov = 1'b0;
  logic slp = 1'b0;
  logic cmd = 1'b0;
  logic mos = 1'b0;
  logic mon = 1'b0;
  logic [2:0] ph = 3'h0;
  logic [7:0] mv = 8'h00;
  logic pull = 1'b0;
  logic pin;
  logic oe;
  logic rg;
  logic rs;
  logic sw;
  fault_cfg_pkg::isolation_action_type iso;
  logic [31:0] echo;
  logic echo_v;
  logic [31:0] rd_v;
  logic err_v;
  int fail_count = 0;
  int n_checks = 0;

  initial forever #4 clk = ~clk;

  fault_isolation_ctrl i_fault_isolation_ctrl (
    .clk_in(clk), .rst_in(rst), .ce_in(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_events_in(ev), .logic_overvoltage_in(ov), .sleep_in(slp),
    .reverse_gate_cmd_in(cmd), .reverse_mosfet_state_in(mos),
    .reverse_gate_monitor_in(mon), .phase_off_in(ph), .neg_overcurrent_mv_in(mv),
    .fault_pin_in(pin), .fault_pin_out(pdat), .fault_pin_oe_out(oe),
    .reverse_gate_out(rg), .reverse_driver_state_out(rs), .sense_switch_out(sw),
    .isolation_out(iso), .status_echo_out(echo), .status_echo_valid_out(echo_v)
  );

  fault_line_model i_fault_line_model (.oe_in(oe), .pull_in(pull), .pin_out(pin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until a rising edge samples pready high; read data is taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic trig();
    @(posedge clk);
    pull <= 1'b1;
    repeat (8) @(posedge clk);
    pull <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset();
    rd(CFG, 32'h0);
    rd(STS, 32'h001);
    chk(oe, 1'b0);
    chk(sw, 1'b0);
    chk(pdat, 1'b0);
    apb(1'b1, 8'h40, 32'h0);
    chk(err_v, 1'b1);
    apb(1'b1, STS, 32'h001);
    rd(STS, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_topology();
    @(posedge clk);
    cmd <= 1'b1;
    mon <= 1'b1;
    settle(4);
    chk(rg, 1'b1);
    chk(rs, 1'b1);
    apb(1'b1, CFG, 32'h001);
    settle(4);
    chk(rg, 1'b0);
    chk(rs, 1'b0);
    @(posedge clk);
    ev <= fault_cfg_pkg::fault_event_type'(9'h002);
    @(posedge clk);
    ev <= '0;
    rd(STS, 32'h0);
    chk(oe, 1'b0);
    apb(1'b1, CFG, 32'h0);
    ev <= fault_cfg_pkg::fault_event_type'(9'h002);
    @(posedge clk);
    ev <= '0;
    settle(3);
    chk(oe, 1'b1);
    rd(STS, 32'h400);
    apb(1'b1, STS, 32'h400);
    $display("test topology done");
  endtask

  task automatic t_latch();
    @(posedge clk);
    ev <= fault_cfg_pkg::fault_event_type'(9'h080);
    settle(3);
    chk(oe, 1'b1);
    apb(1'b1, STS, 32'h0);
    @(negedge clk);
    chk(echo_v, 1'b1);
    chk(echo, 32'h010);
    // Clear while the event is still asserted must not lose it
    apb(1'b1, STS, 32'h010);
    ev <= '0;
    rd(STS, 32'h010);
    apb(1'b1, STS, 32'h010);
    settle(3);
    chk(oe, 1'b0);
    @(posedge clk);
    ev <= fault_cfg_pkg::fault_event_type'(9'h001);
    @(posedge clk);
    ev <= '0;
    settle(3);
    chk(oe, 1'b0);
    rd(STS, 32'h004);
    apb(1'b1, STS, 32'h004);
    $display("test latch done");
  endtask

  task automatic t_sense();
    apb(1'b1, CFG, 32'h002);
    settle(3);
    chk(sw, 1'b1);
    @(posedge clk);
    slp <= 1'b1;
    settle(3);
    chk(sw, 1'b0);
    @(posedge clk);
    slp <= 1'b0;
    apb(1'b1, CFG, 32'h0);
    settle(3);
    chk(sw, 1'b0);
    $display("test sense done");
  endtask

  // An event seen only while the clock enable is low must leave no trace
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    ev <= fault_cfg_pkg::fault_event_type'(9'h100);
    @(posedge clk);
    ev <= '0;
    ce <= 1'b1;
    settle(2);
    chk(oe, 1'b0);
    rd(STS, 32'h0);
    $display("test freeze done");
  endtask

  // Each wait of 1300 cycles outlasts the 1250-cycle blanking after the pin was released
  task automatic t_trigger();
    apb(1'b1, CFG, 32'h0e0);
    ph <= 3'b101;
    repeat (1300) @(posedge clk);
    trig();
    rd(STS, 32'h008);
    chk(oe, 1'b1);
    chk(iso, 32'h1d);
    apb(1'b1, STS, 32'h008);
    settle(3);
    chk(oe, 1'b0);
    chk(iso, 32'h00);
    trig();
    rd(STS, 32'h0);
    apb(1'b1, CFG, 32'h0005_0150);
    mv <= 8'h06;
    repeat (1300) @(posedge clk);
    trig();
    rd(STS, 32'h008);
    chk(oe, 1'b0);
    chk(iso, 32'h00);
    @(posedge clk);
    mv <= 8'h07;
    settle(4);
    chk(iso, 32'h08);
    apb(1'b1, STS, 32'h008);
    mv <= 8'h00;
    ph <= 3'h0;
    $display("test trigger done");
  endtask

  task automatic t_pin_modes();
    int k;
    int ones;
    apb(1'b1, CFG, 32'h004);
    settle(2);
    ones = 0;
    for (k = 0; k < 16; k++)
    begin
      ones += (oe === 1'b1);
      @(negedge clk);
    end
    chk(ones, 32'd8);
    apb(1'b1, CFG, 32'h008);
    settle(3);
    chk(oe, 1'b0);
    @(posedge clk);
    ov <= 1'b1;
    settle(3);
    chk(oe, 1'b1);
    rd(STS, 32'h0);
    @(posedge clk);
    ov <= 1'b0;
    settle(3);
    chk(oe, 1'b0);
    apb(1'b1, CFG, 32'h0);
    $display("test pin modes done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_topology();
    t_latch();
    t_sense();
    t_freeze();
    t_trigger();
    t_pin_modes();
    print_verdict();
  end

  // The tests need under 3000 cycles; a stalled handshake trips this well after
  initial
  begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule
